// file: flash_option_model.sv
// Behavioural flash array that answers the loader's option byte reads.
`timescale 1ns/1ps
`default_nettype none
module flash_option_model
  import option_loader_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_srst,
  input  wire logic                i_req,
  input  wire logic [FLASH_AW-1:0] i_addr,
  input  wire logic                i_slow,
  input  wire logic [3:0][7:0]     i_prim,
  input  wire logic [3:0][7:0]     i_mirr,
  output logic                     o_valid,
  output logic [7:0]               o_data
);
  logic [7:0] byte_q;
  logic [1:0] wait_q;
  // Between answers the lines show the inverse of the last byte, so stale data never matches.
  assign o_data = o_valid ? byte_q : ~byte_q;
  // One pulse per request, after zero or two idle cycles; unknown addresses give a marker.
  always_ff @(posedge i_clk)
  begin
    o_valid <= 1'b0;
    if (i_srst)
    begin
      wait_q <= 2'h0;
      byte_q <= 8'h00;
    end
    else if (i_req && !o_valid)
    begin
      wait_q <= wait_q + 2'h1;
      if (wait_q >= {i_slow, 1'b0})
      begin
        o_valid <= 1'b1;
        wait_q  <= 2'h0;
        byte_q  <= (i_addr[16:2] == OPT_PRIMARY_BASE[16:2]) ? i_prim[i_addr[1:0]] :
                   (i_addr[16:2] == OPT_MIRROR_BASE[16:2]) ? i_mirr[i_addr[1:0]] :
                   8'h5a;
      end
    end
  end
endmodule
`default_nettype wire

// file: option_byte_config_loader.sv
// Option byte loader: fetches four flash bytes at reset and drives the held configuration.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Flash bytes C0h to C3h form the option byte area.
// R2: First three bytes are user options; fourth is the debug option.
// R3: Fetch and apply option bytes after every reset before the core runs.
// R4: Under boot swap fetch from mirror addresses 10C0h to 10C3h instead.
// R5: Software keeps mirror bytes identical to the primary option bytes.
// R6: Byte zero sets watchdog run, standby run, overflow, window, interval interrupt.
// R7: Byte one selects detector mode: interrupt and reset, reset, interrupt, off.
// R8: With detector off, only the external reset pin holds reset.
// R9: Byte one also sets the detector threshold levels.
// R10: Byte two selects low-speed or high-speed main flash mode.
// R11: Byte two sets the on-chip oscillator to 3, 6, 12 or 24 MHz.
// R12: Debug byte enables or disables on-chip debug.
// R13: Debug byte chooses erase or keep of flash on failed authentication.
// R14: Software programs every option byte and leaves unused bits unchanged.
// R15: Watchdog run bit set starts counting after reset, clear keeps stopped.
// R16: Standby run bit clear forces the window open period to full.
// R17: Interval interrupt fires at three quarters of the overflow time.
// R18: Fetched values stay held until the next reset.
module option_byte_config_loader
  import option_loader_pkg::*;
(
  input  wire logic                I_CORE_CLK,
  input  wire logic                I_SRST,
  input  wire logic                I_BOOT_SWAP,
  output logic                     O_FLASH_REQ,
  output logic [FLASH_AW-1:0]      O_FLASH_ADDR,
  input  wire logic                I_FLASH_VALID,
  input  wire logic [7:0]          I_FLASH_DATA,
  input  wire logic                I_RESET_PIN_N,
  input  wire logic                I_LVD_RESET_REQ,
  output logic                     O_RESET_HOLD,
  output logic                     O_CPU_RUN,
  output logic                     O_CFG_VALID,
  output logic                     O_WDT_RUN_EN,
  output logic                     O_WDT_STBY_RUN,
  output logic [1:0]               O_WDT_WINDOW_SEL,
  output logic [2:0]               O_WDT_OVF_SEL,
  output logic [16:0]              O_WDT_OVF_CNT,
  output logic                     O_WDT_IRQ_USE,
  output logic [16:0]              O_WDT_IRQ_CNT,
  output logic [1:0]               O_LVD_MODE,
  output logic [4:0]               O_LVD_LEVEL,
  output logic                     O_HS_MODE,
  output logic [4:0]               O_HOCO_MHZ,
  output logic                     O_DEBUG_EN,
  output logic                     O_ERASE_ON_AUTH_FAIL,
  input  wire logic [AXI_AW-1:0]   S_AXI_AWADDR,
  input  wire logic                S_AXI_AWVALID,
  output logic                     S_AXI_AWREADY,
  input  wire logic [31:0]         S_AXI_WDATA,
  input  wire logic [3:0]          S_AXI_WSTRB,
  input  wire logic                S_AXI_WVALID,
  output logic                     S_AXI_WREADY,
  output logic [1:0]               S_AXI_BRESP,
  output logic                     S_AXI_BVALID,
  input  wire logic                S_AXI_BREADY,
  input  wire logic [AXI_AW-1:0]   S_AXI_ARADDR,
  input  wire logic                S_AXI_ARVALID,
  output logic                     S_AXI_ARREADY,
  output logic [31:0]              S_AXI_RDATA,
  output logic [1:0]               S_AXI_RRESP,
  output logic                     S_AXI_RVALID,
  input  wire logic                S_AXI_RREADY
);

  loader_s q;
  loader_s d;

  // Overflow exponent of the watchdog for each overflow select code.
  function automatic logic [4:0] ovf_exp(input logic [2:0] sel);
    case (sel)
      3'h0:    ovf_exp = 5'h06;
      3'h1:    ovf_exp = 5'h07;
      3'h2:    ovf_exp = 5'h08;
      3'h3:    ovf_exp = 5'h09;
      3'h4:    ovf_exp = 5'h0b;
      3'h5:    ovf_exp = 5'h0d;
      3'h6:    ovf_exp = 5'h0e;
      default: ovf_exp = 5'h10;
    endcase
  endfunction

  // Turns a byte address into a register index, or all ones if misaligned.
  function automatic logic [7:0] reg_index(input logic [AXI_AW-1:0] a);
    if (a[1:0] != 2'h0)
    begin
      reg_index = 8'hff;
    end
    else
    begin
      reg_index = a[9:2];
    end
  endfunction

  logic [7:0]  wdt_b;
  logic [7:0]  lvd_b;
  logic [7:0]  fls_b;
  logic [7:0]  dbg_b;
  logic        pin_low;
  logic        lvd_resets;
  logic [7:0]  rd_idx;
  logic [7:0]  wr_idx;
  logic [31:0] status_word;

  assign wdt_b   = q.opt[0];
  assign lvd_b   = q.opt[1];
  assign fls_b   = q.opt[2];
  assign dbg_b   = q.opt[3];
  assign pin_low = ~q.pin_sync[1];
  assign rd_idx  = reg_index(S_AXI_ARADDR);
  assign wr_idx  = reg_index(q.aw_addr);
  assign status_word = {30'h0, q.swap_used, q.cfg_valid};

  // Only the reset modes of the detector may hold reset; off leaves it to the pin.
  assign lvd_resets = (O_LVD_MODE == LVD_RESET) || (O_LVD_MODE == LVD_IRQ_RESET); // [R7]

  // Next-state logic: flash fetch sequence, pin synchroniser and register slave.
  always_comb
  begin
    d = q;
    d.pin_sync = {q.pin_sync[0], I_RESET_PIN_N};
    case (q.load)
      ST_FETCH:
      begin
        // Boot swap is sampled again for each byte fetch, so a change during the load can mix the two sets.
        d.swap_used = I_BOOT_SWAP; // [R4]
        d.addr = (I_BOOT_SWAP ? OPT_MIRROR_BASE : OPT_PRIMARY_BASE)
               + {15'h0, q.idx}; // [R1] [R4]
        d.req  = 1'b1;
        d.load = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (I_FLASH_VALID)
        begin
          d.opt[q.idx] = I_FLASH_DATA; // [R2]
          d.req = 1'b0;
          if (q.idx == OPT_LAST_IDX)
          begin
            d.cfg_valid = 1'b1; // [R3]
            d.load = ST_DONE;
          end
          else
          begin
            d.idx  = q.idx + 2'h1;
            d.load = ST_FETCH;
          end
        end
      end
      ST_DONE:
      begin
        // Held until the next reset even if flash is rewritten.
        d.load = ST_DONE; // [R18]
      end
      default:
      begin
        d.load = ST_FETCH;
      end
    endcase

    // Write channels are taken independently; the answer waits for both.
    if (S_AXI_AWVALID && S_AXI_AWREADY)
    begin
      d.aw_got  = 1'b1;
      d.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && S_AXI_WREADY)
    begin
      d.w_got  = 1'b1;
      d.w_data = S_AXI_WDATA;
      d.w_strb = S_AXI_WSTRB;
    end
    if (q.aw_got && q.w_got && !q.bvalid)
    begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      if (wr_idx == IDX_CONTROL)
      begin
        d.bresp = RESP_OKAY;
        // The lock only ever sets; it clears with reset alone.
        if (q.w_strb[0] && q.w_data[CTL_LOCK_BIT])
        begin
          d.dbg_lock = 1'b1;
        end
      end
      else
      begin
        d.bresp = RESP_SLVERR;
      end
    end
    if (q.bvalid && S_AXI_BREADY)
    begin
      d.bvalid = 1'b0;
    end

    // Read answer one cycle after the address is taken.
    if (S_AXI_ARVALID && S_AXI_ARREADY)
    begin
      d.rvalid = 1'b1;
      d.rresp  = RESP_OKAY;
      case (rd_idx)
        IDX_WDT_OPT:   d.rdata = {24'h0, wdt_b};
        IDX_LVD_OPT:   d.rdata = {24'h0, lvd_b};
        IDX_FLASH_OPT: d.rdata = {24'h0, fls_b};
        IDX_DEBUG_OPT: d.rdata = {24'h0, dbg_b};
        IDX_STATUS:    d.rdata = status_word;
        IDX_CONTROL:   d.rdata = {31'h0, q.dbg_lock};
        default:
        begin
          d.rdata = 32'h0;
          d.rresp = RESP_SLVERR;
        end
      endcase
    end
    else if (q.rvalid && S_AXI_RREADY)
    begin
      d.rvalid = 1'b0;
    end
  end

  // One register stage for the whole state; reset restarts the fetch.
  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SRST)
    begin
      q          <= '0;
      q.load     <= ST_FETCH; // [R3]
      q.pin_sync <= 2'h0;
    end
    else
    begin
      q <= d;
    end
  end

  // Handshake outputs are combinational; the core waits for the load.
  assign S_AXI_AWREADY = !q.aw_got && !q.bvalid;
  assign S_AXI_WREADY  = !q.w_got && !q.bvalid;
  assign S_AXI_ARREADY = !q.rvalid;
  assign S_AXI_BVALID  = q.bvalid;
  assign S_AXI_BRESP   = q.bresp;
  assign S_AXI_RVALID  = q.rvalid;
  assign S_AXI_RDATA   = q.rdata;
  assign S_AXI_RRESP   = q.rresp;
  assign O_FLASH_REQ   = q.req;
  assign O_FLASH_ADDR  = q.addr;
  assign O_CFG_VALID   = q.cfg_valid;
  assign O_CPU_RUN     = q.cfg_valid && !O_RESET_HOLD; // [R3]

  // Until the detector mode is known only the pin can hold reset.
  assign O_RESET_HOLD = pin_low || (q.cfg_valid && lvd_resets && I_LVD_RESET_REQ); // [R8]

  // Watchdog settings from byte zero.
  assign O_WDT_RUN_EN   = q.cfg_valid && wdt_b[WDT_RUN_BIT]; // [R15]
  assign O_WDT_STBY_RUN = wdt_b[WDT_STBY_BIT]; // [R6]
  assign O_WDT_OVF_SEL  = wdt_b[WDT_OVF_LSB +: 3]; // [R6]
  assign O_WDT_IRQ_USE  = wdt_b[WDT_IRQ_BIT]; // [R6]
  assign O_WDT_WINDOW_SEL = wdt_b[WDT_STBY_BIT] ?
                            {wdt_b[WDT_WIN_HI], wdt_b[WDT_WIN_LO]} : WIN_FULL; // [R16]
  assign O_WDT_OVF_CNT  = 17'h1 << ovf_exp(O_WDT_OVF_SEL);
  // Three quarters by shifts; exact since every overflow count is a power of two.
  assign O_WDT_IRQ_CNT  = (O_WDT_OVF_CNT >> 1) + (O_WDT_OVF_CNT >> 2); // [R17]

  // Detector, flash mode, oscillator and debug settings.
  assign O_LVD_MODE  = lvd_b[LVD_MODE_LSB +: 2]; // [R7]
  assign O_LVD_LEVEL = {lvd_b[LVD_VPOC_LSB +: 3], lvd_b[LVD_LVL_LSB +: 2]}; // [R9]
  assign O_HS_MODE   = fls_b[FLS_HS_BIT]; // [R10]
  assign O_HOCO_MHZ  = 5'h18 >> fls_b[FLS_OSC_LSB +: 2]; // [R11]
  assign O_DEBUG_EN  = q.cfg_valid && dbg_b[DBG_EN_BIT] && !q.dbg_lock; // [R12]
  assign O_ERASE_ON_AUTH_FAIL = !dbg_b[DBG_KEEP_BIT]; // [R13]

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SRST);

  a_fetch_in_area: assert property (O_FLASH_REQ |-> (O_FLASH_ADDR[16:2] ==
      (q.swap_used ? OPT_MIRROR_BASE[16:2] : OPT_PRIMARY_BASE[16:2]))) // [R1]
    else $error("Flash fetch outside the option area.");
  a_swap_mirror: assert property (O_FLASH_REQ && q.swap_used |-> O_FLASH_ADDR[12]) // [R4]
    else $error("Boot swap fetch did not use the mirror.");
  a_run_after_load: assert property (O_CPU_RUN |-> O_CFG_VALID && q.load == ST_DONE && // [R3]
      $past(q.idx) == OPT_LAST_IDX)
    else $error("Core released before options were applied.");
  a_load_bound: assert property ($fell(I_SRST) |-> ##[0:40] O_CFG_VALID || O_FLASH_REQ) // [R3]
    else $error("Option fetch did not start after reset.");
  a_window_full: assert property (O_CFG_VALID && !O_WDT_STBY_RUN |->
      O_WDT_WINDOW_SEL == WIN_FULL) // [R16]
    else $error("Window not forced to full.");
  a_irq_quarter: assert property (O_WDT_IRQ_CNT + (O_WDT_OVF_CNT >> 2) == O_WDT_OVF_CNT) // [R17]
    else $error("Interval point is not three quarters.");
  a_cfg_held: assert property (O_CFG_VALID |=> $stable(q.opt) && O_CFG_VALID) // [R18]
    else $error("Held configuration changed.");
  a_lvd_off_pin: assert property (O_CFG_VALID && O_LVD_MODE == LVD_OFF |->
      O_RESET_HOLD == pin_low) // [R8]
    else $error("Reset hold not from pin alone.");
  a_wdt_run: assert property (!O_CFG_VALID |-> !O_WDT_RUN_EN && !O_DEBUG_EN) // [R15]
    else $error("Watchdog or debug active before load.");
  a_debug_bit: assert property (O_DEBUG_EN |-> q.opt[3][DBG_EN_BIT]) // [R12]
    else $error("Debug enabled against its option bit.");
  a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("Read answer missing.");

endmodule

`default_nettype wire

// file: option_byte_config_loader_tb_top.sv
// Self-checking bench for the option byte loader.
`timescale 1ns/1ps
`default_nettype none
module option_byte_config_loader_tb_top
  import option_loader_pkg::*;
;
  logic clk = 1'b0, srst = 1'b1, swap = 1'b0, pin_n = 1'b1, voltage_detector = 1'b0, slow = 1'b0;
  logic req, fv, cfg, hold, run, wrun, stby, iuse, hs, dbg, ers, awr, wr, bv, arr, rv;
  logic [1:0] win, mode, bresp, rresp;
  logic [2:0] osel;
  logic [4:0] lvl, hoco;
  logic [16:0] ocnt, icnt, fa;
  logic [7:0] fd;
  logic [3:0][7:0] prim = '0, mirr = '0;
  logic [11:0] awa = '0, ara = '0;
  logic [31:0] wd = '0, rd;
  logic awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic [3:0] ws = 4'hf;
  logic [16:0] seen[$];
  int n_mismatch = 0, n_checks = 0;

  // Free-running core clock.
  always #5 clk = ~clk;

  flash_option_model flash_option_model_inst (.i_clk(clk), .i_srst(srst), .i_req(req),
    .i_addr(fa), .i_slow(slow), .i_prim(prim), .i_mirr(mirr), .o_valid(fv), .o_data(fd));

  option_byte_config_loader option_byte_config_loader_inst (.I_CORE_CLK(clk), .I_SRST(srst),
    .I_BOOT_SWAP(swap), .O_FLASH_REQ(req), .O_FLASH_ADDR(fa), .I_FLASH_VALID(fv),
    .I_FLASH_DATA(fd), .I_RESET_PIN_N(pin_n), .I_LVD_RESET_REQ(voltage_detector), .O_RESET_HOLD(hold),
    .O_CPU_RUN(run), .O_CFG_VALID(cfg), .O_WDT_RUN_EN(wrun), .O_WDT_STBY_RUN(stby),
    .O_WDT_WINDOW_SEL(win), .O_WDT_OVF_SEL(osel), .O_WDT_OVF_CNT(ocnt), .O_WDT_IRQ_USE(iuse),
    .O_WDT_IRQ_CNT(icnt), .O_LVD_MODE(mode), .O_LVD_LEVEL(lvl), .O_HS_MODE(hs),
    .O_HOCO_MHZ(hoco), .O_DEBUG_EN(dbg), .O_ERASE_ON_AUTH_FAIL(ers), .S_AXI_AWADDR(awa),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
    .S_AXI_BREADY(brdy), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rrdy));

  // Record every flash address at the edge where a byte is taken.
  always @(posedge clk)
    if (req && fv)
      seen.push_back(fa);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge clk);
    awa <= a;
    awv <= 1'b1;
    wd <= d;
    wv <= 1'b1;
    brdy <= 1'b1;
    for (t = 0; t < 100 && !bv; t++)
    begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
    end
    r = bresp;
    brdy <= 1'b0;
    if (t == 100) n_mismatch++;
  endtask

  task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int t;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    for (t = 0; t < 100 && !rv; t++)
    begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
    end
    d = rd;
    r = rresp;
    rrdy <= 1'b0;
    if (t == 100) n_mismatch++;
  endtask

  // Three cycles of reset, then a bounded wait for the loaded configuration.
  task automatic boot;
    int t;
    seen.delete();
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk(32'(run), 32'h0);
    for (t = 0; t < 200 && !cfg; t++)
      @(posedge clk);
    chk(32'(t < 200), 32'h1);
  endtask

  // Eight boots sweep every field code except the window bits, always 01; the unused copy differs so a wrong source shows.
  initial
  begin
    logic [3:0][7:0] o;
    logic [16:0] ov;
    logic [31:0] d;
    logic [1:0] r;
    int e[8];
    // Overflow exponents for the eight select codes.
    e = '{6, 7, 8, 9, 11, 13, 14, 16};
    for (int i = 0; i < 8; i++)
    begin
      o = {i[0], 6'h0, i[1], 4'h0, i[0], 1'b0, i[1:0], i[2:0], 1'b1, i[1:0], i[1:0],
           i[2], 2'b01, i[0], i[2:0], i[1]};
      prim <= i[2] ? ~o : o;
      mirr <= i[2] ? o : ~o;
      swap <= i[2];
      slow <= i[1];
      boot;
      chk(32'(seen.size()), 32'h4);
      foreach (seen[k])
        chk(32'(seen[k]), 32'(i[2] ? OPT_MIRROR_BASE : OPT_PRIMARY_BASE) + k);
      prim <= '1;
      mirr <= '1;
      repeat (3) @(posedge clk);
      ov = 17'h1 << e[i];
      chk(32'(wrun), 32'(i[0]));
      chk(32'(stby), 32'(i[1]));
      chk(32'(win), i[1] ? 32'h1 : 32'h3);
      chk(32'(osel), 32'(i[2:0]));
      chk(32'(ocnt), 32'(ov));
      chk(32'(iuse), 32'(i[2]));
      chk(32'(icnt), 32'(ov) * 3 / 4);
      chk(32'(mode), 32'(i[1:0]));
      chk(32'(lvl), {27'h0, i[2:0], i[1:0]});
      chk(32'(hs), 32'(i[0]));
      chk(32'(hoco), 32'h18 >> i[1:0]);
      chk(32'(dbg), 32'(i[0]));
      chk(32'(ers), 32'(!i[1]));
      for (int k = 0; k < 4; k++)
      begin
        axr(12'h300 + 12'(4 * k), d, r);
        chk(d, 32'(o[k]));
        chk(32'(r), 32'(RESP_OKAY));
      end
      axr(12'h310, d, r);
      chk(d, {30'h0, i[2], 1'b1});
      voltage_detector <= 1'b1;
      repeat (2) @(posedge clk);
      chk(32'(hold), 32'(i[1]));
      voltage_detector <= 1'b0;
      pin_n <= 1'b0;
      repeat (4) @(posedge clk);
      chk(32'(run), 32'h0);
      pin_n <= 1'b1;
      repeat (4) @(posedge clk);
      chk(32'(hold), 32'h0);
    end
    // Identical copies, as software keeps them for boot swap, must load the same bytes.
    prim <= o;
    mirr <= o;
    boot;
    axr(12'h300, d, r);
    chk(d, 32'(o[0]));
    axr(12'h30c, d, r);
    chk(d, 32'(o[3]));
    axr(12'h400, d, r);
    chk(d, 32'h0);
    chk(32'(r), 32'(RESP_SLVERR));
    axr(12'h302, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axw(12'h300, 32'h0, r);
    chk(32'(r), 32'(RESP_SLVERR));
    axr(12'h300, d, r);
    chk(d, 32'(o[0]));
    // Without byte lane zero the lock bit must not be written.
    ws <= 4'he;
    axw(12'h314, 32'h1, r);
    chk(32'(r), 32'(RESP_OKAY));
    chk(32'(dbg), 32'h1);
    ws <= 4'hf;
    axw(12'h314, 32'h1, r);
    chk(32'(r), 32'(RESP_OKAY));
    chk(32'(dbg), 32'h0);
    axr(12'h314, d, r);
    chk(d, 32'h1);
    tally_and_finish;
  end

  // Cuts a hang short well beyond the expected run length.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    tally_and_finish;
  end
endmodule
`default_nettype wire

// file: option_loader_pkg.sv
// Package with constants, types and state of the option byte configuration loader.
package option_loader_pkg;

  // Flash addresses of the option byte area and of its boot-swap mirror.
  localparam int          FLASH_AW        = 17;
  localparam logic [16:0] OPT_PRIMARY_BASE = 17'h000c0;
  localparam logic [16:0] OPT_MIRROR_BASE  = 17'h010c0;
  localparam int          OPT_COUNT        = 4;
  localparam logic [1:0]  OPT_LAST_IDX     = 2'h3;

  // Register indices; byte address is four times the index.
  localparam logic [7:0]  IDX_WDT_OPT      = 8'hc0;
  localparam logic [7:0]  IDX_LVD_OPT      = 8'hc1;
  localparam logic [7:0]  IDX_FLASH_OPT    = 8'hc2;
  localparam logic [7:0]  IDX_DEBUG_OPT    = 8'hc3;
  localparam logic [7:0]  IDX_STATUS       = 8'hc4;
  localparam logic [7:0]  IDX_CONTROL      = 8'hc5;
  localparam int          AXI_AW           = 12;

  // Watchdog option byte fields.
  localparam int WDT_STBY_BIT  = 0;
  localparam int WDT_OVF_LSB   = 1;
  localparam int WDT_RUN_BIT   = 4;
  localparam int WDT_WIN_LO    = 5;
  localparam int WDT_WIN_HI    = 6;
  localparam int WDT_IRQ_BIT   = 7;
  localparam logic [1:0] WIN_FULL = 2'h3;

  // Voltage detector option byte fields and modes.
  localparam int LVD_MODE_LSB  = 0;
  localparam int LVD_LVL_LSB   = 2;
  localparam int LVD_VPOC_LSB  = 5;
  localparam logic [1:0] LVD_OFF       = 2'h0;
  localparam logic [1:0] LVD_IRQ_ONLY  = 2'h1;
  localparam logic [1:0] LVD_IRQ_RESET = 2'h2;
  localparam logic [1:0] LVD_RESET     = 2'h3;

  // Flash mode and oscillator byte fields.
  localparam int FLS_OSC_LSB   = 0;
  localparam int FLS_HS_BIT    = 3;

  // Debug option byte fields.
  localparam int DBG_KEEP_BIT  = 0;
  localparam int DBG_EN_BIT    = 7;

  // Status and control register bits.
  localparam int ST_DONE_BIT   = 0;
  localparam int ST_SWAP_BIT   = 1;
  localparam int CTL_LOCK_BIT  = 0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_WAIT  = 2'b01,
    ST_DONE  = 2'b10
  } load_e;

  // Whole state of the loader in one packed word.
  typedef struct packed {
    load_e                 load;
    logic [1:0]            idx;
    logic                  req;
    logic [FLASH_AW-1:0]   addr;
    logic                  swap_used;
    logic [3:0][7:0]       opt;
    logic                  cfg_valid;
    logic                  dbg_lock;
    logic [1:0]            pin_sync;
    logic                  aw_got;
    logic [AXI_AW-1:0]     aw_addr;
    logic                  w_got;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } loader_s;

endpackage
